// [verilog/sra_pkg.sv]
// sra_pkg: constants for the secure region access sequencer
// assumes word addressing from the host controller, 16-bit data
package sra_pkg;
  localparam int          ADDR_W         = 24;
  localparam int          DATA_W         = 16;
  localparam int          REGION_WORDS   = 256;
  localparam int          REGION_AW      = 8;
  localparam int          PART_WORDS     = 128;
  localparam int          BANK_W         = 4;
  localparam int          SECTOR_AW      = 15;
  localparam int          BANK_LSB       = 20;
  localparam logic [11:0] UNLOCK1_ADDR   = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR   = 12'h2aa;
  localparam logic [15:0] UNLOCK1_DATA   = 16'h00aa;
  localparam logic [15:0] UNLOCK2_DATA   = 16'h0055;
  localparam logic [15:0] ENTRY_DATA     = 16'h0088;
  localparam logic [15:0] PROGRAM_DATA   = 16'h00a0;
  localparam logic [15:0] EXIT_DATA      = 16'h0090;
  localparam logic [15:0] EXIT_FINAL     = 16'h0000;
  localparam logic [15:0] LOCK_CMD_DATA  = 16'h00c5;
  localparam logic [7:0]  ID_LOCK_ADDR   = 8'h03;
  localparam int          FACT_LOCK_BIT  = 7;
  localparam int          CUST_LOCK_BIT  = 6;
  localparam logic [15:0] INVALID_DATA   = 16'hffff;
  localparam logic [15:0] ERASED_WORD    = 16'hffff;
  localparam int          RESET_PULSE_MIN_WIDTH_NS = 200;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          RESET_PULSE_CYCLES =
    (RESET_PULSE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    SRA_IDLE, SRA_UNL1, SRA_UNL2, SRA_PROG, SRA_EXIT
  } sra_seq_e;
endpackage

// [verilog/sra_region_mem.sv]
// sra_region_mem: 256-word secure region storage with one-shot customer lock
// assumes writes arrive pre-qualified from the sequencer
`timescale 1ns/1ns
module sra_region_mem
  import sra_pkg::*;
#(
  parameter int WORDS = REGION_WORDS
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 wr_en,
  input  wire logic [REGION_AW-1:0] wr_addr,
  input  wire logic [DATA_W-1:0]    wr_data,
  input  wire logic                 lock_en,
  input  wire logic [REGION_AW-1:0] rd_addr,
  output logic      [DATA_W-1:0]    rd_data,
  output logic                      cust_locked
);
  import sra_pkg::*;
  logic [DATA_W-1:0] mem_r [WORDS];
  logic              cust_locked_r;

  // customer part writes only while unlocked; factory part never written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_r[i] <= ERASED_WORD;
      end
    end else if (wr_en && !cust_locked_r && wr_addr[REGION_AW-1]) begin
      mem_r[wr_addr] <= mem_r[wr_addr] & wr_data;
    end
  end

  // lock only ever sets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cust_locked_r <= 1'b0;
    end else if (lock_en) begin
      cust_locked_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= ERASED_WORD;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end

  assign cust_locked = cust_locked_r;

  a_lock_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cust_locked_r) |-> cust_locked_r) else $error("customer lock cleared");
  a_fact_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && !wr_addr[REGION_AW-1]) |=> mem_r[$past(wr_addr)] == $past(mem_r[wr_addr]))
    else $error("factory word changed");
  a_locked_frozen: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_en && cust_locked_r) |=> mem_r[$past(wr_addr)] == $past(mem_r[wr_addr]))
    else $error("locked customer word changed");
endmodule

// [verilog/sra_top.sv]
// sra_top: command sequencer and read mux for the secure region
// assumes synchronous host strobes on ref_clk, array data supplied by the array core
`timescale 1ns/1ns
module sra_top
  import sra_pkg::*;
#(
  parameter int RST_CYCLES = RESET_PULSE_CYCLES
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  input  wire logic              burst_start,
  input  wire logic              burst_next,
  input  wire logic              sync_mode,
  input  wire logic              id_mode,
  input  wire logic              lock_cmd,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              embedded_busy,
  input  wire logic [DATA_W-1:0] array_rdata,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe,
  output logic                   region_mode,
  output logic                   array_wr_en,
  output logic                   array_rd_en,
  output logic                   accel_prog_en,
  output logic                   bypass_en,
  output logic                   cfg_clear,
  output logic                   cmd_reject
);
  import sra_pkg::*;
  logic                 rs1_r, rs2_r;
  logic                 rst_sync_n;
  sra_seq_e             seq_r;
  logic                 region_r;
  logic                 pgm_busy_r;
  logic [REGION_AW-1:0] burst_addr_r;
  logic [REGION_AW-1:0] burst_addr_nxt;
  logic [DATA_W-1:0]    rd_out_nxt;
  logic                 oe_r;
  logic                 reject_r;
  logic                 sel_region_r, sel_id_r, sel_inval_r;
  logic [DATA_W-1:0]    mem_rdata;
  logic                 cust_locked;
  logic                 mem_wr;
  logic [REGION_AW-1:0] mem_rd_addr;
  logic                 hit_sector0, hit_bank0, in_range;
  logic [7:0]           rst_cnt_r;

  function automatic logic cyc_ok(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                                  input logic [11:0] ea, input logic [DATA_W-1:0] ed);
    cyc_ok = (a[11:0] == ea) && (d == ed);
  endfunction

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  assign rst_sync_n = rs2_r;

  // cycles since internal reset release, saturating at the settle count
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rst_cnt_r <= 8'h00;
    end else if (rst_cnt_r < 8'(RST_CYCLES)) begin
      rst_cnt_r <= rst_cnt_r + 8'h01;
    end
  end
  assign cfg_clear = !rst_sync_n;

  assign hit_sector0 = (addr[ADDR_W-1:SECTOR_AW] == '0);
  assign hit_bank0   = (addr[ADDR_W-1:BANK_LSB] == '0);
  assign in_range    = (addr[SECTOR_AW-1:REGION_AW] == '0);

  // command sequencer
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seq_r <= SRA_IDLE;
    end else if (wr_stb && !embedded_busy) begin
      unique case (seq_r)
        SRA_IDLE: seq_r <= cyc_ok(addr, wdata, UNLOCK1_ADDR, UNLOCK1_DATA) ? SRA_UNL1 : SRA_IDLE;
        SRA_UNL1: seq_r <= cyc_ok(addr, wdata, UNLOCK2_ADDR, UNLOCK2_DATA) ? SRA_UNL2 : SRA_IDLE;
        SRA_UNL2: begin
          if (cyc_ok(addr, wdata, UNLOCK1_ADDR, PROGRAM_DATA) && region_r) begin
            seq_r <= SRA_PROG;
          end else if (cyc_ok(addr, wdata, UNLOCK1_ADDR, EXIT_DATA) && region_r) begin
            seq_r <= SRA_EXIT;
          end else begin
            seq_r <= SRA_IDLE;
          end
        end
        SRA_PROG: seq_r <= SRA_IDLE;
        SRA_EXIT: seq_r <= SRA_IDLE;
      endcase
    end
  end

  // region mode flag: set by entry, cleared only by exit or reset
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      region_r <= 1'b0;
    end else if (wr_stb && !embedded_busy) begin
      if (seq_r == SRA_UNL2 && cyc_ok(addr, wdata, UNLOCK1_ADDR, ENTRY_DATA)) begin
        region_r <= 1'b1;
      end else if (seq_r == SRA_EXIT && wdata == EXIT_FINAL) begin
        region_r <= 1'b0;
      end
    end
  end

  assign mem_wr = wr_stb && !embedded_busy && seq_r == SRA_PROG && region_r
                  && hit_sector0 && in_range;

  // customer programming marker
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pgm_busy_r <= 1'b0;
    end else begin
      pgm_busy_r <= mem_wr;
    end
  end
  assign accel_prog_en = !(pgm_busy_r || region_r);
  assign bypass_en     = !(pgm_busy_r || region_r);

  // burst address: wraps inside the region; the advanced address is read at once
  always_comb begin
    burst_addr_nxt = burst_addr_r;
    if (burst_start) begin
      burst_addr_nxt = addr[REGION_AW-1:0];
    end else if (burst_next && sync_mode) begin
      burst_addr_nxt = burst_addr_r + REGION_AW'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      burst_addr_r <= '0;
    end else begin
      burst_addr_r <= burst_addr_nxt;
    end
  end
  assign mem_rd_addr = sync_mode ? burst_addr_nxt : addr[REGION_AW-1:0];

  sra_region_mem #(
    .WORDS (REGION_WORDS)
  ) u_mem (
    .clk         (ref_clk),
    .rst_n       (rst_sync_n),
    .wr_en       (mem_wr),
    .wr_addr     (addr[REGION_AW-1:0]),
    .wr_data     (wdata),
    .lock_en     (lock_cmd && region_r && !embedded_busy),
    .rd_addr     (mem_rd_addr),
    .rd_data     (mem_rdata),
    .cust_locked (cust_locked)
  );

  // read path select, registered with the memory read
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sel_region_r <= 1'b0;
      sel_id_r     <= 1'b0;
      sel_inval_r  <= 1'b0;
      oe_r         <= 1'b0;
      reject_r     <= 1'b0;
    end else begin
      sel_id_r     <= id_mode && addr[REGION_AW-1:0] == ID_LOCK_ADDR;
      sel_region_r <= region_r && hit_sector0 && !embedded_busy;
      sel_inval_r  <= region_r && hit_sector0 && !in_range && !sync_mode;
      oe_r         <= rd_stb || (burst_next && sync_mode);
      reject_r     <= region_r && (embedded_busy || (hit_bank0 && !hit_sector0)) && (rd_stb || wr_stb);
    end
  end

  always_comb begin
    rd_out_nxt = array_rdata;
    if (sel_id_r) begin
      rd_out_nxt = '0;
      rd_out_nxt[FACT_LOCK_BIT] = 1'b1;
      rd_out_nxt[CUST_LOCK_BIT] = cust_locked;
    end else if (sel_inval_r) begin
      rd_out_nxt = INVALID_DATA;
    end else if (sel_region_r) begin
      rd_out_nxt = mem_rdata;
    end else if (reject_r) begin
      rd_out_nxt = INVALID_DATA;
    end
  end

  // data output register, tristated under reset
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else begin
      dq_out <= rd_out_nxt;
      dq_oe  <= oe_r;
    end
  end

  assign region_mode = region_r;
  assign array_wr_en = wr_stb && !(region_r && hit_bank0);
  assign array_rd_en = rd_stb && !(region_r && hit_bank0 && !hit_sector0);
  assign cmd_reject  = reject_r;

  a_entry_maps: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_stb && !embedded_busy && seq_r == SRA_UNL2 && cyc_ok(addr, wdata, UNLOCK1_ADDR, ENTRY_DATA))
    |=> region_r) else $error("entry did not map region");
  a_exit_restores: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_stb && !embedded_busy && seq_r == SRA_EXIT && wdata == EXIT_FINAL) |=> !region_r)
    else $error("exit did not restore array");
  a_mode_persists: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (region_r && !(seq_r == SRA_EXIT && wr_stb)) |=> region_r) else $error("mode dropped");
  a_bad_cycle: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_stb && !embedded_busy && seq_r == SRA_UNL1 && !cyc_ok(addr, wdata, UNLOCK2_ADDR, UNLOCK2_DATA))
    |=> seq_r == SRA_IDLE && region_r == $past(region_r)) else $error("bad cycle kept");
  a_bank0_block: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (region_r && hit_bank0) |-> !array_wr_en) else $error("bank 0 write in region mode");
  a_busy_noprog: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    embedded_busy |-> !mem_wr) else $error("region write while busy");
  a_accel_off: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    mem_wr |=> !accel_prog_en && !bypass_en) else $error("accel during customer program");
  a_burst_wrap: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (burst_addr_r == 8'hff && burst_next && sync_mode && !burst_start) |=> burst_addr_r == 8'h00)
    else $error("burst did not wrap");
  a_id_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    sel_id_r |=> dq_out[FACT_LOCK_BIT]) else $error("factory flag not 1");
  a_reset_tristate: assert property (@(posedge ref_clk)
    !rst_sync_n |-> !dq_oe && !region_r) else $error("outputs on in reset");

  a_ignore_busy: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_stb && embedded_busy) |=> seq_r == $past(seq_r) && region_r == $past(region_r))
    else $error("command taken while busy");
  a_prog_once: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_stb && !embedded_busy && seq_r == SRA_PROG) |=> seq_r == SRA_IDLE)
    else $error("program state kept");
  a_entry_only: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (!region_r && !(wr_stb && !embedded_busy && seq_r == SRA_UNL2)) |=> !region_r)
    else $error("region mapped without entry");
  a_first_unlock: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (wr_stb && !embedded_busy && seq_r == SRA_IDLE && !cyc_ok(addr, wdata, UNLOCK1_ADDR, UNLOCK1_DATA))
    |=> seq_r == SRA_IDLE) else $error("bad first cycle kept");
  a_lock_needs_mode: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (lock_cmd && !region_r) |=> cust_locked == $past(cust_locked))
    else $error("lock outside region mode");
  a_region_data: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (sel_region_r && !sel_id_r && !sel_inval_r) |=> dq_out == $past(mem_rdata))
    else $error("region read data wrong");
  a_array_data: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (!sel_region_r && !sel_id_r && !sel_inval_r && !reject_r) |=> dq_out == $past(array_rdata))
    else $error("array read data wrong");
  a_beyond_inval: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (sel_inval_r && !sel_id_r) |=> dq_out == INVALID_DATA)
    else $error("read beyond region not invalid");
  a_reject_inval: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (reject_r && !sel_id_r) |=> dq_out == INVALID_DATA)
    else $error("rejected read returned data");
  a_reject_bank0: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (region_r && hit_bank0 && !hit_sector0 && (rd_stb || wr_stb)) |=> cmd_reject)
    else $error("bank 0 access not rejected");
  a_cust_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    sel_id_r |=> dq_out[CUST_LOCK_BIT] == $past(cust_locked))
    else $error("customer flag wrong");
  a_read_oe: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (rd_stb || (burst_next && sync_mode)) |=> ##1 dq_oe)
    else $error("read not driven");
  a_reset_quiet: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (rst_cnt_r == 8'h00 && RST_CYCLES > 0) |-> !region_r && !dq_oe && seq_r == SRA_IDLE)
    else $error("state left after reset");

  c_entry: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) $rose(region_r));
  c_exit: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) $fell(region_r));
  c_program: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) mem_wr);
  c_wrap: cover property (@(posedge ref_clk) disable iff (!rst_sync_n)
    burst_addr_r == 8'hff ##1 burst_addr_r == 8'h00);
  c_id_read: cover property (@(posedge ref_clk) disable iff (!rst_sync_n) sel_id_r);
endmodule

// [sim/sra_host_model.sv]
// sra_host_model: host memory controller issuing command writes and reads
// assumes ref_clk from the bench; drives all its outputs at the falling edge
`timescale 1ns/1ns
module sra_host_model
  import sra_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic [DATA_W-1:0] dq_out,
  output logic                   wr_stb,
  output logic                   rd_stb,
  output logic                   burst_start,
  output logic                   burst_next,
  output logic                   sync_mode,
  output logic                   id_mode,
  output logic                   lock_cmd,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata
);
  initial begin
    {wr_stb, rd_stb, burst_start, burst_next, sync_mode, id_mode, lock_cmd} = 7'h00;
    addr = 24'h000000;
    wdata = 16'h0000;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge ref_clk);
    wr_stb = 1'b1;
    addr = a;
    wdata = d;
    @(negedge ref_clk);
    wr_stb = 1'b0;
    wdata = ~d;
  endtask
  // unlock pair then the command word at 555
  task automatic cmd(input logic [DATA_W-1:0] c);
    wr(24'h000555, UNLOCK1_DATA);
    wr(24'h0002aa, UNLOCK2_DATA);
    wr(24'h000555, c);
  endtask
  // k: 0 plain read, 1 burst load, 2 burst advance; bursts wrap from the top of the region to word 0
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] k, output logic [DATA_W-1:0] q);
    @(negedge ref_clk);
    addr = a;
    rd_stb = (k != 2'd2);
    burst_start = (k == 2'd1);
    burst_next = (k == 2'd2);
    @(negedge ref_clk);
    {rd_stb, burst_start, burst_next} = 3'h0;
    // data and enable stand for one cycle, from the second rising edge
    @(negedge ref_clk);
    q = dq_out;
  endtask
  task automatic mode(input logic s, input logic i);
    @(negedge ref_clk);
    {sync_mode, id_mode} = {s, i};
  endtask
  task automatic lock;
    @(negedge ref_clk);
    lock_cmd = 1'b1;
    @(negedge ref_clk);
    lock_cmd = 1'b0;
  endtask
endmodule

// [sim/secure_region_access_sequencer_tb.sv]
// secure_region_access_sequencer_tb: scenario tasks around sra_top
// assumes the host model drives commands; bench owns reset, busy and array data
`timescale 1ns/1ns
module secure_region_access_sequencer_tb
  import sra_pkg::*;
;
  logic              ref_clk, rst_n, embedded_busy, rej_seen, wr_gate, rd_gate;
  logic              wr_stb, rd_stb, burst_start, burst_next, sync_mode, id_mode, lock_cmd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, array_rdata, dq_out, q;
  logic              dq_oe, region_mode, array_wr_en, array_rd_en, accel_prog_en, bypass_en, cfg_clear, cmd_reject;
  int                miscompares, n_compared, cyc;
  assign array_rdata = addr[15:0] ^ 16'h5a5a;
  sra_top #(.RST_CYCLES(2)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .burst_start(burst_start), .burst_next(burst_next), .sync_mode(sync_mode), .id_mode(id_mode),
    .lock_cmd(lock_cmd), .addr(addr), .wdata(wdata), .embedded_busy(embedded_busy), .array_rdata(array_rdata),
    .dq_out(dq_out), .dq_oe(dq_oe), .region_mode(region_mode), .array_wr_en(array_wr_en),
    .array_rd_en(array_rd_en), .accel_prog_en(accel_prog_en), .bypass_en(bypass_en), .cfg_clear(cfg_clear),
    .cmd_reject(cmd_reject));
  sra_host_model host_u (.ref_clk(ref_clk), .dq_out(dq_out), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .burst_start(burst_start), .burst_next(burst_next), .sync_mode(sync_mode), .id_mode(id_mode),
    .lock_cmd(lock_cmd), .addr(addr), .wdata(wdata));
  task automatic chk16(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic test_done;
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    host_u.cmd(PROGRAM_DATA);
    host_u.wr(a, d);
  endtask
  task automatic enter_chk;
    host_u.cmd(ENTRY_DATA);
    @(negedge ref_clk);
    chk1("region_mode", 1'b1, region_mode);
  endtask
  task automatic t_refused;
    embedded_busy = 1'b1;
    host_u.cmd(ENTRY_DATA);
    @(negedge ref_clk);
    chk1("region_mode", 1'b0, region_mode);
    embedded_busy = 1'b0;
    host_u.wr(24'h000555, UNLOCK1_DATA);
    host_u.wr(24'h0002ab, UNLOCK2_DATA);
    host_u.wr(24'h000555, ENTRY_DATA);
    @(negedge ref_clk);
    chk1("region_mode", 1'b0, region_mode);
    host_u.rd(24'h000010, 2'd0, q);
    chk16("array", 16'h0010 ^ 16'h5a5a, q);
    chk1("dq_oe", 1'b1, dq_oe);
    chk1("accel", 1'b1, accel_prog_en);
  endtask
  task automatic t_map;
    enter_chk();
    chk1("accel", 1'b0, accel_prog_en);
    chk1("bypass", 1'b0, bypass_en);
    host_u.rd(24'h100010, 2'd0, q);
    chk16("bank1", 16'h0010 ^ 16'h5a5a, q);
    chk1("rd_gate", 1'b1, rd_gate);
    host_u.rd(24'h000100, 2'd0, q);
    chk16("beyond", INVALID_DATA, q);
    rej_seen = 1'b0;
    host_u.rd(24'h008000, 2'd0, q);
    chk1("reject", 1'b1, rej_seen);
    chk16("rejected", INVALID_DATA, q);
    chk1("rd_gate", 1'b0, rd_gate);
    embedded_busy = 1'b1;
    rej_seen = 1'b0;
    host_u.rd(24'h000010, 2'd0, q);
    chk1("busy_reject", 1'b1, rej_seen);
    chk16("busy_read", INVALID_DATA, q);
    embedded_busy = 1'b0;
    host_u.wr(24'h100000, 16'h1234);
    chk1("wr_gate", 1'b1, wr_gate);
    host_u.wr(24'h008000, 16'h1234);
    chk1("wr_gate", 1'b0, wr_gate);
  endtask
  task automatic t_prog;
    prog(24'h0000fe, 16'h0aaa);
    prog(24'h0000ff, 16'h0bbb);
    prog(24'h000005, 16'h0000);
    host_u.rd(24'h0000fe, 2'd0, q);
    chk16("cust", 16'h0aaa, q);
    host_u.rd(24'h000005, 2'd0, q);
    chk16("fact", ERASED_WORD, q);
    host_u.mode(1'b1, 1'b0);
    host_u.rd(24'h0000fe, 2'd1, q);
    chk16("burst0", 16'h0aaa, q);
    host_u.rd(24'h0000fe, 2'd2, q);
    chk16("burst1", 16'h0bbb, q);
    chk1("burst_oe", 1'b1, dq_oe);
    host_u.rd(24'h0000fe, 2'd2, q);
    chk16("wrap", ERASED_WORD, q);
  endtask
  task automatic t_lock;
    host_u.mode(1'b0, 1'b1);
    host_u.rd(24'h000003, 2'd0, q);
    chk1("fact_flag", 1'b1, q[FACT_LOCK_BIT]);
    chk1("cust_flag", 1'b0, q[CUST_LOCK_BIT]);
    host_u.lock();
    host_u.rd(24'h000003, 2'd0, q);
    chk1("cust_flag", 1'b1, q[CUST_LOCK_BIT]);
    host_u.mode(1'b0, 1'b0);
    prog(24'h0000fe, 16'h0000);
    host_u.rd(24'h0000fe, 2'd0, q);
    chk16("locked", 16'h0aaa, q);
  endtask
  task automatic t_exit;
    host_u.rd(24'h000010, 2'd0, q);
    chk1("region_mode", 1'b1, region_mode);
    host_u.cmd(EXIT_DATA);
    host_u.wr(24'h123456, EXIT_FINAL);
    @(negedge ref_clk);
    chk1("region_mode", 1'b0, region_mode);
    chk1("accel", 1'b1, accel_prog_en);
    chk1("bypass", 1'b1, bypass_en);
    host_u.rd(24'h0000fe, 2'd0, q);
    chk16("array", 16'h00fe ^ 16'h5a5a, q);
  endtask
  task automatic t_reset;
    enter_chk();
    rst_n = 1'b0;
    @(negedge ref_clk);
    chk1("dq_oe", 1'b0, dq_oe);
    chk1("cfg_clear", 1'b1, cfg_clear);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk1("region_mode", 1'b0, region_mode);
    enter_chk();
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cmd_reject === 1'b1) rej_seen = 1'b1;
    if (wr_stb === 1'b1) wr_gate = array_wr_en;
    if (rd_stb === 1'b1) rd_gate = array_rd_en;
    if (cyc == 5000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    {rst_n, embedded_busy, rej_seen} = 3'b000;
    repeat (12) @(negedge ref_clk);
    chk1("cfg_clear", 1'b1, cfg_clear);
    chk1("region_mode", 1'b0, region_mode);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_refused();
    t_map();
    t_prog();
    t_lock();
    t_exit();
    t_reset();
    test_done();
  end
endmodule
